// [negop_core.sv]
// Datapath block for negate, idle, invert, or and port output, with an
// AXI4-Lite register port. Assumes a single 25 MHz clock shared with the
// bus master; every bus signal is synchronous to it.
// Overview of operation
// - Negate gives all-ones minus operand plus one
// - Negating zero yields zero, zero flag set, sign and carry clear
// - Most negative value stays, overflow flag set
// - Idle changes nothing, flags untouched
// - Invert forms one's complement, flags untouched
// - Or sets bits, clears carry and overflow
// - Output sends low byte or word, flags kept
// - Port from 8-bit immediate or pointer
`timescale 1ns/1ps
`default_nettype none

module negop_core
    import negop_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             port_out_valid,
    output logic [15:0]      port_out_addr,
    output logic [15:0]      port_out_data,
    output logic             port_out_word
);
    import negop_pkg::*;

    core_state_t s_q;
    core_state_t s_d;

    logic        do_write;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        exec;
    op_code_t    ex_op;
    logic        ex_word;
    logic        ex_ptr;
    logic [7:0]  ex_imm;
    logic [15:0] alu_result;
    logic [11:0] alu_flags;
    logic [15:0] flag_merge;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] v;
        v = old;
        if (strb[0])
            v[7:0] = data[7:0];
        if (strb[1])
            v[15:8] = data[15:8];
        return v;
    endfunction : merge16

    assign awready = !s_q.aw_got && !s_q.bvalid;
    assign wready  = !s_q.w_got && !s_q.bvalid;
    assign arready = !s_q.rvalid;
    assign bvalid  = s_q.bvalid;
    assign bresp   = s_q.bresp;
    assign rvalid  = s_q.rvalid;
    assign rdata   = s_q.rdata;
    assign rresp   = s_q.rresp;
    assign port_out_valid = s_q.out_valid;
    assign port_out_addr  = s_q.out_port;
    assign port_out_data  = s_q.out_data;
    assign port_out_word  = s_q.out_word;

    // Address and data may arrive in either order; write commits once both held
    assign wr_addr  = s_q.aw_got ? s_q.awaddr : awaddr;
    assign wr_data  = s_q.w_got ? s_q.wdata : wdata;
    assign wr_strb  = s_q.w_got ? s_q.wstrb : wstrb;
    assign do_write = (s_q.aw_got || (awvalid && awready))
                   && (s_q.w_got || (wvalid && wready));

    // A write to the control word with byte lane 0 strobed launches the operation it names
    assign exec    = do_write && (wr_addr == `OFF_CTRL) && wr_strb[0];
    assign ex_op   = op_code_t'(wr_data[`CTRL_OP_MSB:`CTRL_OP_LSB]);
    assign ex_word = wr_data[`CTRL_WORD];
    assign ex_ptr  = wr_data[`CTRL_USE_PTR];
    assign ex_imm  = wr_strb[1] ? wr_data[`CTRL_IMM_MSB:`CTRL_IMM_LSB]
                                : s_q.ctrl[`CTRL_IMM_MSB:`CTRL_IMM_LSB];

    // Flag word is 12 bits; the merge works on 16, upper nibble dropped
    assign flag_merge = merge16({4'h0, s_q.flags}, wr_data, wr_strb);

    op_unit i_op_unit (
        .op        (ex_op),
        .word      (ex_word),
        .dest      (s_q.dest),
        .src       (s_q.src),
        .flags_in  (s_q.flags),
        .result    (alu_result),
        .flags_out (alu_flags)
    );

    always_comb
    begin
        s_d = s_q;
        s_d.out_valid = 1'b0;
        if (awvalid && awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = awaddr;
        end
        if (wvalid && wready)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata = wdata;
            s_d.wstrb = wstrb;
        end
        if (s_q.bvalid && bready)
            s_d.bvalid = 1'b0;
        if (do_write)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = `RESP_OKAY;
            unique case (wr_addr)
                `OFF_CTRL:
                begin
                    s_d.ctrl = merge16(s_q.ctrl, wr_data, wr_strb);
                    if (exec)
                    begin
                        s_d.dest  = alu_result;
                        s_d.flags = alu_flags;
                        if (ex_op == OP_OUT)
                        begin
                            s_d.out_valid = 1'b1;
                            s_d.out_word  = ex_word;
                            s_d.out_port  = ex_ptr ? s_q.ptr
                                                   : {8'h00, ex_imm};
                            s_d.out_data  = ex_word ? s_q.acc
                                          : {8'h00, s_q.acc[7:0]};
                            s_d.out_cnt   = s_q.out_cnt + 16'h0001;
                        end
                    end
                end
                `OFF_DEST:  s_d.dest = merge16(s_q.dest, wr_data, wr_strb);
                `OFF_SRC:   s_d.src  = merge16(s_q.src, wr_data, wr_strb);
                `OFF_ACC:   s_d.acc  = merge16(s_q.acc, wr_data, wr_strb);
                `OFF_PTR:   s_d.ptr  = merge16(s_q.ptr, wr_data, wr_strb);
                `OFF_FLAGS:
                begin
                    s_d.flags = flag_merge[11:0];
                end
                `OFF_STATUS: s_d.bresp = `RESP_OKAY;
                default:     s_d.bresp = `RESP_SLVERR;
            endcase
        end
        if (s_q.rvalid && rready)
            s_d.rvalid = 1'b0;
        if (arvalid && arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = `RESP_OKAY;
            unique case (araddr)
                `OFF_CTRL:   s_d.rdata = {16'h0000, s_q.ctrl};
                `OFF_DEST:   s_d.rdata = {16'h0000, s_q.dest};
                `OFF_SRC:    s_d.rdata = {16'h0000, s_q.src};
                `OFF_ACC:    s_d.rdata = {16'h0000, s_q.acc};
                `OFF_PTR:    s_d.rdata = {16'h0000, s_q.ptr};
                `OFF_FLAGS:  s_d.rdata = {20'h00000, s_q.flags};
                `OFF_STATUS: s_d.rdata = {16'h0000, s_q.out_cnt};
                default:
                begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = `RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_neg_value;
        exec && ex_op == OP_NEG && ex_word
        |=> s_q.dest == 16'h0000 - $past(s_q.dest);
    endproperty
    a_neg_value: assert property (p_neg_value)
        else $error("negate word result wrong");

    property p_neg_zero;
        exec && ex_op == OP_NEG && s_q.dest == 16'h0000
        |=> s_q.dest == 16'h0000 && s_q.flags[`FLG_ZF]
            && !s_q.flags[`FLG_SF] && !s_q.flags[`FLG_CF];
    endproperty
    a_neg_zero: assert property (p_neg_zero)
        else $error("negate of zero not zero");

    property p_neg_most;
        exec && ex_op == OP_NEG && !ex_word && s_q.dest[7:0] == 8'h80
        |=> s_q.dest[7:0] == 8'h80 && s_q.flags[`FLG_OF];
    endproperty
    a_neg_most: assert property (p_neg_most)
        else $error("most negative byte mishandled");

    property p_idle;
        exec && ex_op == OP_IDLE
        |=> $stable(s_q.flags) && $stable(s_q.dest) && !port_out_valid;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle changed state");

    property p_not;
        exec && ex_op == OP_NOT && ex_word
        |=> s_q.dest == ~$past(s_q.dest) && $stable(s_q.flags);
    endproperty
    a_not: assert property (p_not)
        else $error("invert wrong or flags moved");

    property p_or;
        exec && ex_op == OP_OR
        |=> !s_q.flags[`FLG_CF] && !s_q.flags[`FLG_OF]
            && s_q.flags[`FLG_ZF] == (s_q.dest[7:0] == 8'h00 &&
               ($past(ex_word) ? s_q.dest[15:8] == 8'h00 : 1'b1));
    endproperty
    a_or: assert property (p_or)
        else $error("or flags wrong");

    property p_out_data;
        exec && ex_op == OP_OUT && !ex_word
        |=> port_out_valid && port_out_data == {8'h00, $past(s_q.acc[7:0])}
            && $stable(s_q.flags) ##1 !port_out_valid;
    endproperty
    a_out_data: assert property (p_out_data)
        else $error("byte output data wrong");

    property p_out_port;
        exec && ex_op == OP_OUT && ex_ptr
        |=> port_out_addr == $past(s_q.ptr);
    endproperty
    a_out_port: assert property (p_out_port)
        else $error("pointer port number wrong");

    property p_byte_width;
        exec && !ex_word
        |=> s_q.dest[15:8] == $past(s_q.dest[15:8]);
    endproperty
    a_byte_width: assert property (p_byte_width)
        else $error("byte op touched upper byte");

    property p_neg_ctl_flags;
        exec && ex_op == OP_NEG
        |=> s_q.flags[`FLG_DF:`FLG_TF] == $past(s_q.flags[`FLG_DF:`FLG_TF])
            && s_q.flags[`FLG_CF] == ($past(s_q.dest[7:0]) != 8'h00
               || ($past(ex_word) && $past(s_q.dest[15:8]) != 8'h00));
    endproperty
    a_neg_ctl_flags: assert property (p_neg_ctl_flags)
        else $error("negate flags wrong");

    c_neg_word: cover property (exec && ex_op == OP_NEG && ex_word);
    c_or_byte:  cover property (exec && ex_op == OP_OR && !ex_word);
    c_out_ptr:  cover property (exec && ex_op == OP_OUT && ex_ptr);
    c_rd_back:  cover property (rvalid && rready);

endmodule : negop_core
`default_nettype wire

// [negop_consts.svh]
// Constants for the negate/invert/or/output datapath block.
// Assumes a 32-bit AXI4-Lite register port with byte addresses.
`ifndef NEGOP_CONSTS_SVH
`define NEGOP_CONSTS_SVH

// Register byte offsets
`define OFF_CTRL   8'h00
`define OFF_DEST   8'h04
`define OFF_SRC    8'h08
`define OFF_ACC    8'h0C
`define OFF_PTR    8'h10
`define OFF_FLAGS  8'h14
`define OFF_STATUS 8'h18

// Control register fields
`define CTRL_OP_LSB   0
`define CTRL_OP_MSB   2
`define CTRL_WORD     3
`define CTRL_USE_PTR  4
`define CTRL_IMM_LSB  8
`define CTRL_IMM_MSB  15

// Operation codes
`define OPC_IDLE 3'h0
`define OPC_NEG  3'h1
`define OPC_NOT  3'h2
`define OPC_OR   3'h3
`define OPC_OUT  3'h4

// Flag bit positions in the flag word
`define FLG_CF 0
`define FLG_PF 2
`define FLG_AF 4
`define FLG_ZF 6
`define FLG_SF 7
`define FLG_TF 8
`define FLG_IF 9
`define FLG_DF 10
`define FLG_OF 11

// Reset values and bus answers
`define FLAGS_RST  12'h000
`define RESP_OKAY  2'h0
`define RESP_SLVERR 2'h2

`endif

// [negop_pkg.sv]
// Types shared by the datapath block and its operation unit.
// Assumes negop_consts.svh is on the include path.
`include "negop_consts.svh"

package negop_pkg;

    typedef enum logic [2:0] {
        OP_IDLE = `OPC_IDLE,
        OP_NEG  = `OPC_NEG,
        OP_NOT  = `OPC_NOT,
        OP_OR   = `OPC_OR,
        OP_OUT  = `OPC_OUT
    } op_code_t;

    typedef struct packed {
        logic        aw_got;
        logic [7:0]  awaddr;
        logic        w_got;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [15:0] ctrl;
        logic [15:0] dest;
        logic [15:0] src;
        logic [15:0] acc;
        logic [15:0] ptr;
        logic [11:0] flags;
        logic [15:0] out_cnt;
        logic        out_valid;
        logic [15:0] out_port;
        logic [15:0] out_data;
        logic        out_word;
    } core_state_t;

endpackage : negop_pkg

// [op_unit.sv]
// Combinational operation unit: result and flags for one operation.
// Assumes the caller registers the outputs; no state is held here.
`timescale 1ns/1ps
`default_nettype none

module op_unit
    import negop_pkg::*;
(
    input  wire negop_pkg::op_code_t op,
    input  wire logic           word,
    input  wire logic [15:0]    dest,
    input  wire logic [15:0]    src,
    input  wire logic [11:0]    flags_in,
    output logic      [15:0]    result,
    output logic      [11:0]    flags_out
);
    import negop_pkg::*;

    logic [15:0] mask;
    logic [15:0] operand;
    logic [15:0] raw;
    logic        most_neg;

    always_comb
    begin
        mask      = word ? 16'hFFFF : 16'h00FF;
        operand   = dest & mask;
        raw       = 16'h0000;
        result    = dest;
        flags_out = flags_in;
        most_neg  = word ? (operand == 16'h8000) : (operand == 16'h0080);
        unique case (op)
            OP_NEG:
            begin
                // Zero and the most negative value come back unchanged
                raw = ((16'hFFFF - operand) + 16'h0001) & mask;
                result = (dest & ~mask) | raw;
                flags_out[`FLG_CF] = (operand != 16'h0000);
                flags_out[`FLG_OF] = most_neg;
                flags_out[`FLG_AF] = (operand[3:0] != 4'h0);
                flags_out[`FLG_ZF] = (raw == 16'h0000);
                flags_out[`FLG_SF] = word ? raw[15] : raw[7];
                flags_out[`FLG_PF] = ~^raw[7:0];
            end
            OP_NOT:
            begin
                raw = (16'hFFFF - operand) & mask;
                result = (dest & ~mask) | raw;
            end
            OP_OR:
            begin
                raw = (operand | src) & mask;
                result = (dest & ~mask) | raw;
                flags_out[`FLG_CF] = 1'b0;
                flags_out[`FLG_OF] = 1'b0;
                // Aux carry is undefined here; cleared for repeatability
                flags_out[`FLG_AF] = 1'b0;
                flags_out[`FLG_ZF] = (raw == 16'h0000);
                flags_out[`FLG_SF] = word ? raw[15] : raw[7];
                flags_out[`FLG_PF] = ~^raw[7:0];
            end
            OP_IDLE, OP_OUT:
            begin
                result = dest;
            end
            default:
            begin
                result = dest;
            end
        endcase
    end

endmodule : op_unit
`default_nettype wire

// [negate_invert_or_output_ops_tb.sv]
// Self-checking bench for the negate/invert/or/output datapath block.
// Assumes negop_consts.svh on the include path, negop_pkg compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "negop_consts.svh"

module negate_invert_or_output_ops_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [7:0]  awaddr = 8'h00;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [1:0]  bresp;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [7:0]  araddr = 8'h00;
    logic        rvalid;
    logic        rready = 1'b0;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        pvalid;
    logic [15:0] paddr;
    logic [15:0] pdata;
    logic        pword;
    logic [15:0] last_addr;
    logic [15:0] last_data;
    logic        last_word;
    int          pulses = 0;
    int          cycles = 0;
    int          n_fail = 0;
    int          compares = 0;

    always #20 clock = ~clock;

    negop_core i_negop_core (
        .clock(clock), .rst(rst), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .port_out_valid(pvalid),
        .port_out_addr(paddr), .port_out_data(pdata),
        .port_out_word(pword)
    );

    // Counting every high cycle exposes a strobe that is held too long
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (pvalid === 1'b1)
        begin
            pulses    <= pulses + 1;
            last_addr <= paddr;
            last_data <= pdata;
            last_word <= pword;
        end
        if (cycles == 5000)
        begin
            n_fail++;
            test_done;
        end
    end

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clock);
    endtask : rd

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, 4'h3, r);
        check({30'h0, r}, {30'h0, `RESP_OKAY});
    endtask : put

    task automatic peek(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check({30'h0, r}, {30'h0, `RESP_OKAY});
        check(d, e);
    endtask : peek

    task automatic exec(input logic [2:0] op, input logic w, input logic p,
                        input logic [7:0] imm);
        put(`OFF_CTRL, {16'h0000, imm, 3'b000, p, w, op});
    endtask : exec

    function automatic logic [11:0] szp(input logic [15:0] r,
                                        input logic w);
        logic [11:0] f;
        f = 12'h000;
        f[`FLG_PF] = ~^r[7:0];
        f[`FLG_ZF] = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
        f[`FLG_SF] = w ? r[15] : r[7];
        return f;
    endfunction : szp

    task automatic t_reset;
        for (int i = 0; i < 7; i++)
            peek(8'(4 * i), 32'h0);
        put(`OFF_DEST, 32'h0000_1111);
        do_reset(2);
        peek(`OFF_DEST, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_neg;
        logic [15:0] v [5] = '{16'h0001, 16'h0000, 16'h8000, 16'hAB80,
                               16'h1234};
        logic        w [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        logic [15:0] e;
        logic [11:0] f;
        for (int i = 0; i < 5; i++)
        begin
            put(`OFF_FLAGS, 32'h0000_0700);
            put(`OFF_DEST, {16'h0000, v[i]});
            exec(`OPC_NEG, w[i], 1'b0, 8'h00);
            e = w[i] ? (16'hFFFF - v[i]) + 16'h0001
                     : {v[i][15:8], (8'hFF - v[i][7:0]) + 8'h01};
            f = 12'h700 | szp(e, w[i]);
            f[`FLG_CF] = w[i] ? (v[i] != 16'h0) : (v[i][7:0] != 8'h00);
            f[`FLG_AF] = v[i][3:0] != 4'h0;
            f[`FLG_OF] = w[i] ? (v[i] == 16'h8000) : (v[i][7:0] == 8'h80);
            peek(`OFF_DEST, {16'h0000, e});
            peek(`OFF_FLAGS, {20'h0, f});
        end
        $display("test negate done");
    endtask : t_neg

    task automatic t_keep;
        logic [2:0]  op [4] = '{`OPC_NOT, `OPC_NOT, `OPC_IDLE, 3'h5};
        logic        w [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        logic [15:0] e [4] = '{16'hA53C, 16'hA5C3, 16'hA5C3, 16'hA5C3};
        put(`OFF_FLAGS, 32'h0000_0FD5);
        put(`OFF_DEST, 32'h0000_5AC3);
        for (int i = 0; i < 4; i++)
        begin
            exec(op[i], w[i], 1'b0, 8'h00);
            peek(`OFF_DEST, {16'h0000, e[i]});
            peek(`OFF_FLAGS, 32'h0000_0FD5);
        end
        $display("test invert and idle done");
    endtask : t_keep

    task automatic t_or;
        logic [15:0] d [3] = '{16'h0F00, 16'h8000, 16'h0000};
        logic [15:0] s [3] = '{16'h00F0, 16'h0001, 16'h0000};
        logic        w [3] = '{1'b1, 1'b0, 1'b1};
        logic [15:0] e;
        for (int i = 0; i < 3; i++)
        begin
            put(`OFF_FLAGS, 32'h0000_0FD5);
            put(`OFF_DEST, {16'h0000, d[i]});
            put(`OFF_SRC, {16'h0000, s[i]});
            exec(`OPC_OR, w[i], 1'b0, 8'h00);
            e = w[i] ? d[i] | s[i] : {d[i][15:8], d[i][7:0] | s[i][7:0]};
            peek(`OFF_DEST, {16'h0000, e});
            peek(`OFF_FLAGS, {20'h0, 12'h700 | szp(e, w[i])});
        end
        $display("test or done");
    endtask : t_or

    task automatic t_out;
        logic [1:0]  m [4] = '{2'b00, 2'b11, 2'b01, 2'b10};
        logic [7:0]  imm [4] = '{8'hFF, 8'h12, 8'h00, 8'h34};
        logic [31:0] c0;
        logic [1:0]  r;
        int          p0;
        put(`OFF_ACC, 32'h0000_BEEF);
        put(`OFF_PTR, 32'h0000_FFFF);
        put(`OFF_FLAGS, 32'h0000_0FD5);
        put(`OFF_DEST, 32'h0000_1357);
        rd(`OFF_STATUS, c0, r);
        for (int i = 0; i < 4; i++)
        begin
            p0 = pulses;
            exec(`OPC_OUT, m[i][0], m[i][1], imm[i]);
            check(pulses - p0, 32'h1);
            check({16'h0, last_addr},
                  m[i][1] ? 32'hFFFF : {24'h0, imm[i]});
            check({16'h0, last_data},
                  m[i][0] ? 32'hBEEF : 32'h00EF);
            check({31'h0, last_word}, {31'h0, m[i][0]});
        end
        peek(`OFF_FLAGS, 32'h0000_0FD5);
        peek(`OFF_DEST, 32'h0000_1357);
        peek(`OFF_STATUS, c0 + 32'h4);
        $display("test output done");
    endtask : t_out

    task automatic t_err;
        logic [31:0] d;
        logic [1:0]  r;
        rd(8'h1C, d, r);
        check({30'h0, r}, {30'h0, `RESP_SLVERR});
        check(d, 32'h0);
        put(`OFF_DEST, 32'h0000_2222);
        wr(8'h20, 32'h0000_FFFF, 4'h3, r);
        check({30'h0, r}, {30'h0, `RESP_SLVERR});
        // Low lane only: the high byte must survive
        wr(`OFF_DEST, 32'h0000_9999, 4'h1, r);
        peek(`OFF_DEST, 32'h0000_2299);
        rd(`OFF_STATUS, d, r);
        put(`OFF_STATUS, 32'h0000_5555);
        peek(`OFF_STATUS, d);
        $display("test bus errors done");
    endtask : t_err

    initial
    begin
        do_reset(8);
        t_reset;
        t_neg;
        t_keep;
        t_or;
        t_out;
        t_err;
        test_done;
    end
endmodule : negate_invert_or_output_ops_tb
`default_nettype wire
